/* File: design/pe_reset_addr_select.sv */
// reset, address select and port state of the i2c port expander
// assumes linkClock is a free-running sampling clock several times faster than scl
`timescale 1ns/100ps
`default_nettype none
module pe_reset_addr_select (
    // clocks and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic linkClock,
    // i2c bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // address select and abort pins
    input wire logic addrSelectLow,
    input wire logic addrSelectHigh,
    input wire logic busAbort_n,
    // port pins
    input wire logic [7:0] portLevelIn,
    output pe_pkg::pe_port_drive_type portDrive,
    // change alert
    output logic changeAlert_n
);
    import pe_pkg::*;

    typedef struct packed {
        pe_link_pins_type sync1;
        pe_link_pins_type sync2;
        logic sclPrev;
        logic sdaPrev;
        pe_link_state_type fsm;
        logic [3:0] bitCnt;
        logic [7:0] shiftReg;
        logic isRead;
        logic inRead;
        logic byteSel;
        logic wrSecond;
        logic sdaOe;
        logic sdaOut;
        pe_sel_track_type trkLow;
        pe_sel_track_type trkHigh;
        logic [3:0] snapshot;
        logic [3:0] flags;
        logic [3:0] heldFlags;
        logic [7:0] mask;
        logic alertPend;
        logic alertLvl;
        logic wrPulse;
        logic [7:0] wrByte;
        logic clsPulse;
        pe_addr_class_type cls;
        logic [1:0] settle;
    } pe_link_reg_type;

    typedef struct packed {
        logic [1:0] selSync1;
        logic [1:0] selSync2;
        logic alertSync1;
        logic alertSync2;
        logic [1:0] strapCnt;
        logic strapDone;
        pe_port_drive_type drive;
        logic alert_n;
    } pe_main_reg_type;

    pe_link_reg_type l_q, l_d;
    pe_main_reg_type m_q, m_d;
    logic [1:0] linkRst_q;
    logic linkArst_n;
    pe_link_pins_type pinsIn;
    pe_link_pins_type s;
    pe_addr_class_type clsNow;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic linesStable;
    logic [3:0] portChange;
    logic wrValid;
    logic [7:0] wrData;
    logic clsValid;
    pe_addr_class_type clsData;

    ////////////////////////////////////////////////////////////////////////////
    // link-side reset release, so the link logic leaves reset on its own edge
    always_ff @(posedge linkClock or negedge arst_n) begin
        if (!arst_n) begin
            linkRst_q <= 2'h0;
        end else begin
            linkRst_q <= {linkRst_q[0], 1'b1};
        end
    end

    assign linkArst_n = linkRst_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // link-side decode of the synchronised pins
    assign pinsIn = '{scl: sclIn, sda: sdaIn, selLow: addrSelectLow, selHigh: addrSelectHigh,
                      abort_n: busAbort_n, port: portLevelIn};
    assign s = l_q.sync2;
    assign sclRise = s.scl && !l_q.sclPrev;
    assign sclFall = !s.scl && l_q.sclPrev;
    assign startCond = s.scl && l_q.sclPrev && !s.sda && l_q.sdaPrev;
    assign stopCond = s.scl && l_q.sclPrev && s.sda && !l_q.sdaPrev;
    assign linesStable = (s.scl == l_q.sclPrev) && (s.sda == l_q.sdaPrev);
    assign portChange = s.port[PE_ODIO_MSB:PE_ODIO_LSB] ^ l_q.snapshot;
    assign clsNow.high = pe_classify(l_q.trkHigh, s.selHigh);
    assign clsNow.low = pe_classify(l_q.trkLow, s.selLow);

    ////////////////////////////////////////////////////////////////////////////
    // serial interface, transition detection and select tracking
    always_comb begin
        l_d = l_q;
        l_d.sync1 = pinsIn;
        l_d.sync2 = l_q.sync1;
        l_d.sclPrev = s.scl;
        l_d.sdaPrev = s.sda;
        l_d.wrPulse = 1'b0;
        l_d.clsPulse = 1'b0;
        l_d.sdaOut = 1'b0;

        // changes accumulate every cycle; a clear below absorbs them into the snapshot
        l_d.flags = l_q.flags | portChange;
        if (|(portChange & l_q.mask[PE_ODIO_MSB:PE_ODIO_LSB])) begin
            l_d.alertPend = 1'b1;
        end

        // sync chain not yet filled
        if (l_q.settle != PE_STRAP_WAIT) begin
            l_d.settle = l_q.settle + 2'h1;
            l_d.snapshot = s.port[PE_ODIO_MSB:PE_ODIO_LSB];
            l_d.flags = 4'h0;
            l_d.alertPend = 1'b0;
        end

        // watch select pins only while scl and sda sit still, to dodge sync skew
        if (linesStable && (l_q.fsm != PE_IDLE)) begin
            l_d.trkLow.diffScl = l_q.trkLow.diffScl | (s.selLow != s.scl);
            l_d.trkLow.diffSda = l_q.trkLow.diffSda | (s.selLow != s.sda);
            l_d.trkLow.seenHigh = l_q.trkLow.seenHigh | s.selLow;
            l_d.trkLow.seenLow = l_q.trkLow.seenLow | !s.selLow;
            l_d.trkHigh.diffScl = l_q.trkHigh.diffScl | (s.selHigh != s.scl);
            l_d.trkHigh.diffSda = l_q.trkHigh.diffSda | (s.selHigh != s.sda);
            l_d.trkHigh.seenHigh = l_q.trkHigh.seenHigh | s.selHigh;
            l_d.trkHigh.seenLow = l_q.trkHigh.seenLow | !s.selHigh;
        end

        case (l_q.fsm)
            PE_ADDR: begin
                if (sclRise) begin
                    l_d.shiftReg = {l_q.shiftReg[6:0], s.sda};
                    l_d.bitCnt = l_q.bitCnt + 4'h1;
                end else if (sclFall && (l_q.bitCnt == PE_BITS_PER_BYTE)) begin
                    if (l_q.shiftReg[7:1] == pe_slave_addr(clsNow)) begin
                        l_d.fsm = PE_ADDR_ACK;
                        l_d.sdaOe = 1'b1;
                        l_d.isRead = l_q.shiftReg[0];
                        l_d.bitCnt = 4'h0;
                        // sample ports, hand old flags to the read, drop the alert
                        l_d.shiftReg = s.port;
                        l_d.snapshot = s.port[PE_ODIO_MSB:PE_ODIO_LSB];
                        l_d.heldFlags = l_q.flags | portChange;
                        l_d.flags = 4'h0;
                        l_d.alertPend = 1'b0;
                        l_d.byteSel = 1'b0;
                    end else begin
                        l_d.fsm = PE_IGNORE;
                    end
                end
            end
            PE_ADDR_ACK: begin
                if (sclFall) begin
                    if (l_q.isRead) begin
                        l_d.fsm = PE_RD_DATA;
                        l_d.inRead = 1'b1;
                        l_d.sdaOe = !l_q.shiftReg[7];
                    end else begin
                        l_d.fsm = PE_WR_DATA;
                        l_d.sdaOe = 1'b0;
                    end
                end
            end
            PE_WR_DATA: begin
                if (sclRise) begin
                    l_d.shiftReg = {l_q.shiftReg[6:0], s.sda};
                    l_d.bitCnt = l_q.bitCnt + 4'h1;
                end else if (sclFall && (l_q.bitCnt == PE_BITS_PER_BYTE)) begin
                    l_d.fsm = PE_WR_ACK;
                    l_d.sdaOe = 1'b1;
                    if (!l_q.wrSecond) begin
                        l_d.wrPulse = 1'b1;
                        l_d.wrByte = l_q.shiftReg;
                        l_d.wrSecond = 1'b1;
                    end else begin
                        l_d.mask = l_q.shiftReg;
                    end
                end
            end
            PE_WR_ACK: begin
                if (sclFall) begin
                    l_d.fsm = PE_WR_DATA;
                    l_d.sdaOe = 1'b0;
                    l_d.bitCnt = 4'h0;
                end
            end
            PE_RD_DATA: begin
                if (sclFall) begin
                    if (l_q.bitCnt == PE_LAST_TX_BIT) begin
                        l_d.fsm = PE_RD_ACK;
                        l_d.sdaOe = 1'b0;
                        l_d.bitCnt = 4'h0;
                    end else begin
                        l_d.shiftReg = {l_q.shiftReg[6:0], 1'b0};
                        l_d.bitCnt = l_q.bitCnt + 4'h1;
                        l_d.sdaOe = !l_q.shiftReg[6];
                    end
                end
            end
            PE_RD_ACK: begin
                if (sclRise && s.sda) begin
                    l_d.fsm = PE_IGNORE; // master declined more data
                end else if (sclFall) begin
                    l_d.fsm = PE_RD_DATA;
                    l_d.byteSel = !l_q.byteSel;
                    if (!l_q.byteSel) begin
                        l_d.shiftReg = {2'h0, l_q.heldFlags, 2'h0};
                        l_d.sdaOe = 1'b1;
                    end else begin
                        // a new pair: resample and restart change tracking
                        l_d.shiftReg = s.port;
                        l_d.snapshot = s.port[PE_ODIO_MSB:PE_ODIO_LSB];
                        l_d.heldFlags = l_q.flags | portChange;
                        l_d.flags = 4'h0;
                        l_d.alertPend = 1'b0;
                        l_d.sdaOe = !s.port[7];
                    end
                end
            end
            PE_IDLE, PE_IGNORE: begin
                l_d.sdaOe = 1'b0;
            end
            default: begin
                l_d.fsm = PE_IDLE;
                l_d.sdaOe = 1'b0;
            end
        endcase

        // bus conditions override any bit-level activity
        if (startCond) begin
            l_d.fsm = PE_ADDR;
            l_d.bitCnt = 4'h0;
            l_d.sdaOe = 1'b0;
            l_d.wrSecond = 1'b0;
            l_d.inRead = 1'b0;
            l_d.trkLow = '0;
            l_d.trkHigh = '0;
        end else if (stopCond) begin
            l_d.fsm = PE_IDLE;
            l_d.sdaOe = 1'b0;
            l_d.inRead = 1'b0;
            if (l_q.fsm != PE_IDLE) begin
                l_d.clsPulse = 1'b1;
                l_d.cls = clsNow;
            end
        end

        // abort ends the transfer as a stop would but sends no select decode, flags and alert kept
        if (!s.abort_n) begin
            l_d.fsm = PE_IDLE;
            l_d.sdaOe = 1'b0;
            l_d.inRead = 1'b0;
        end

        // alert held back while a read is running, shown at its stop
        l_d.alertLvl = l_d.alertPend && !l_d.inRead;
    end

    always_ff @(posedge linkClock or negedge linkArst_n) begin
        if (!linkArst_n) begin
            l_q <= '0;
            l_q.sync1 <= '1;
            l_q.sync2 <= '1;
            l_q.sclPrev <= 1'b1;
            l_q.sdaPrev <= 1'b1;
            l_q.fsm <= PE_IDLE;
            l_q.mask <= PE_MASK_RESET;
        end else begin
            l_q <= l_d;
        end
    end

    assign sdaOe = l_q.sdaOe;
    assign sdaOut = l_q.sdaOut;

    ////////////////////////////////////////////////////////////////////////////
    // words from the link side into the main domain
    pe_word_sync #(.WIDTH(8)) wrSync (
        .srcClock(linkClock),
        .srcArst_n(linkArst_n),
        .srcPulse(l_q.wrPulse),
        .srcData(l_q.wrByte),
        .dstClock(clock),
        .dstArst_n(arst_n),
        .dstValid(wrValid),
        .dstData(wrData)
    );

    pe_word_sync #(.WIDTH(4)) clsSync (
        .srcClock(linkClock),
        .srcArst_n(linkArst_n),
        .srcPulse(l_q.clsPulse),
        .srcData(l_q.cls),
        .dstClock(clock),
        .dstArst_n(arst_n),
        .dstValid(clsValid),
        .dstData(clsData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // main domain: port levels, pullups and the alert pin
    always_comb begin
        m_d = m_q;
        m_d.selSync1 = {addrSelectHigh, addrSelectLow};
        m_d.selSync2 = m_q.selSync1;
        m_d.alertSync1 = l_q.alertLvl;
        m_d.alertSync2 = m_q.alertSync1;
        m_d.alert_n = !m_q.alertSync2;
        m_d.drive.odioOut = 4'h0;

        // strap: plain high/low of each select once the sync chain has filled
        if (!m_q.strapDone) begin
            if (m_q.strapCnt == PE_STRAP_WAIT) begin
                m_d.strapDone = 1'b1;
                m_d.drive.pp = {{2{m_q.selSync2[1]}}, {2{m_q.selSync2[0]}}};
                m_d.drive.odioOe = ~{{2{m_q.selSync2[1]}}, {2{m_q.selSync2[0]}}};
                m_d.drive.pullupEn = {{2{m_q.selSync2[1]}}, {2{m_q.selSync2[0]}}};
            end else begin
                m_d.strapCnt = m_q.strapCnt + 2'h1;
            end
        end

        // pullups follow the full four-level decode after every transmission that ends in a stop, not an abort
        if (clsValid) begin
            m_d.drive.pullupEn[3:2] = {2{clsData.high != PE_SEL_GND}};
            m_d.drive.pullupEn[1:0] = {2{clsData.low != PE_SEL_GND}};
        end

        // only the four io ports own pullup enables; push-pull has none
        if (wrValid) begin
            m_d.drive.pp = {wrData[7], wrData[6], wrData[1], wrData[0]};
            m_d.drive.odioOe = ~wrData[PE_ODIO_MSB:PE_ODIO_LSB];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            m_q.selSync1 <= 2'h3;
            m_q.selSync2 <= 2'h3;
            m_q.alertSync1 <= 1'b0;
            m_q.alertSync2 <= 1'b0;
            m_q.strapCnt <= 2'h0;
            m_q.strapDone <= 1'b0;
            m_q.drive.pp <= PE_OUT_RESET;
            m_q.drive.odioOut <= 4'h0;
            m_q.drive.odioOe <= ~PE_OUT_RESET;
            m_q.drive.pullupEn <= PE_PULL_RESET;
            m_q.alert_n <= 1'b1;
        end else begin
            m_q <= m_d;
        end
    end

    assign portDrive = m_q.drive;
    assign changeAlert_n = m_q.alert_n;

endmodule : pe_reset_addr_select
`default_nettype wire

/* File: design/pe_pkg.sv */
// constants, types and decode helpers for the port expander reset and address select block
// assumes nothing; imported by the main module and the word crossing
package pe_pkg;

    // power-up values and the fixed address bits
    localparam logic [7:0] PE_MASK_RESET = 8'h3C;
    localparam logic [3:0] PE_OUT_RESET = 4'hF;
    localparam logic [3:0] PE_PULL_RESET = 4'hF;
    localparam logic [2:0] PE_ADDR_FIXED = 3'h6;

    // byte layout of the port byte
    localparam int PE_ODIO_LSB = 2;
    localparam int PE_ODIO_MSB = 5;

    // bit counts and waits
    localparam logic [3:0] PE_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] PE_LAST_TX_BIT = 4'h7;
    localparam logic [1:0] PE_STRAP_WAIT = 2'h3;

    // four-level select input connection
    typedef enum logic [1:0] {
        PE_SEL_GND = 2'h0,
        PE_SEL_VDD = 2'h1,
        PE_SEL_SCL = 2'h2,
        PE_SEL_SDA = 2'h3
    } pe_sel_class_type;

    typedef struct packed {
        pe_sel_class_type high;
        pe_sel_class_type low;
    } pe_addr_class_type;

    // what one select input was seen to do during a transmission
    typedef struct packed {
        logic diffScl;
        logic diffSda;
        logic seenHigh;
        logic seenLow;
    } pe_sel_track_type;

    // pins seen by the link side
    typedef struct packed {
        logic scl;
        logic sda;
        logic selLow;
        logic selHigh;
        logic abort_n;
        logic [7:0] port;
    } pe_link_pins_type;

    // pp index 0..3 = outputs zero, one, six, seven; odio index 0..3 = ports two..five
    typedef struct packed {
        logic [3:0] pp;
        logic [3:0] odioOut;
        logic [3:0] odioOe;
        logic [3:0] pullupEn;
    } pe_port_drive_type;

    // serial interface states, one-hot
    typedef enum logic [7:0] {
        PE_IDLE = 8'h01,
        PE_ADDR = 8'h02,
        PE_ADDR_ACK = 8'h04,
        PE_WR_DATA = 8'h08,
        PE_WR_ACK = 8'h10,
        PE_RD_DATA = 8'h20,
        PE_RD_ACK = 8'h40,
        PE_IGNORE = 8'h80
    } pe_link_state_type;

    // fixed levels win; otherwise the line it never disagreed with
    function automatic pe_sel_class_type pe_classify(input pe_sel_track_type t, input logic level);
        pe_sel_class_type c;
        if (t.seenHigh && !t.seenLow) begin
            c = PE_SEL_VDD;
        end else if (t.seenLow && !t.seenHigh) begin
            c = PE_SEL_GND;
        end else if (!t.seenHigh && !t.seenLow) begin
            c = level ? PE_SEL_VDD : PE_SEL_GND;
        end else if (!t.diffScl) begin
            c = PE_SEL_SCL;
        end else begin
            c = PE_SEL_SDA;
        end
        return c;
    endfunction : pe_classify

    // slave address from the two select classes
    function automatic logic [6:0] pe_slave_addr(input pe_addr_class_type c);
        logic [1:0] hi;
        logic [1:0] lo;
        case (c.high)
            PE_SEL_SCL: hi = 2'h0;
            PE_SEL_SDA: hi = 2'h1;
            PE_SEL_GND: hi = 2'h2;
            default: hi = 2'h3;
        endcase
        lo = c.low;
        return {PE_ADDR_FIXED, hi, lo};
    endfunction : pe_slave_addr

endpackage : pe_pkg

/* File: design/pe_word_sync.sv */
// carries a word with a one-cycle valid from one clock domain to another
// assumes pulses are spaced far wider than a few destination cycles
`timescale 1ns/100ps
`default_nettype none
module pe_word_sync #(
    parameter int WIDTH = 8
) (
    // source side
    input wire logic srcClock,
    input wire logic srcArst_n,
    input wire logic srcPulse,
    input wire logic [WIDTH-1:0] srcData,
    // destination side
    input wire logic dstClock,
    input wire logic dstArst_n,
    output logic dstValid,
    output logic [WIDTH-1:0] dstData
);
    import pe_pkg::*;

    typedef struct packed {
        logic toggle;
        logic [WIDTH-1:0] data;
    } pe_src_state_type;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic seen;
        logic valid;
        logic [WIDTH-1:0] data;
    } pe_dst_state_type;

    pe_src_state_type src_q, src_d;
    pe_dst_state_type dst_q, dst_d;

    ////////////////////////////////////////////////////////////////////////////
    // source: hold the word and flip the toggle once per event
    always_comb begin
        src_d = src_q;
        if (srcPulse) begin
            src_d.toggle = ~src_q.toggle;
            src_d.data = srcData;
        end
    end

    always_ff @(posedge srcClock or negedge srcArst_n) begin
        if (!srcArst_n) begin
            src_q <= '0;
        end else begin
            src_q <= src_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // destination: data is only taken once the toggle has settled, so it is stable
    always_comb begin
        dst_d = dst_q;
        dst_d.sync1 = src_q.toggle;
        dst_d.sync2 = dst_q.sync1;
        dst_d.seen = dst_q.sync2;
        dst_d.valid = dst_q.sync2 ^ dst_q.seen;
        if (dst_q.sync2 ^ dst_q.seen) begin
            dst_d.data = src_q.data;
        end
    end

    always_ff @(posedge dstClock or negedge dstArst_n) begin
        if (!dstArst_n) begin
            dst_q <= '0;
        end else begin
            dst_q <= dst_d;
        end
    end

    assign dstValid = dst_q.valid;
    assign dstData = dst_q.data;

endmodule : pe_word_sync
`default_nettype wire

/* File: dv/pe_reset_addr_select_monitor.sv */
// port checker for reset, abort and strap defaults of the port expander block
// assumes it is bound onto pe_reset_addr_select and the bus idles after each reset
`timescale 1ns/100ps
`default_nettype none
module pe_reset_addr_select_monitor (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // pins watched
    input wire logic sdaOe,
    input wire logic addrSelectLow,
    input wire logic addrSelectHigh,
    input wire logic busAbort_n,
    input wire logic [7:0] portLevelIn,
    input wire pe_pkg::pe_port_drive_type portDrive,
    input wire logic changeAlert_n
);
    import pe_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // steps after release of reset and of a held abort
    sequence relDone;
        $rose(arst_n) ##6 1'b1;
    endsequence
    sequence quietStart;
        $rose(arst_n) ##0 $stable(portLevelIn) [*8] ##1 $stable(portLevelIn) [*8];
    endsequence
    sequence abortHeld;
        !busAbort_n [*8];
    endsequence
    chk_reset_quiet: assert property ($rose(arst_n) |-> changeAlert_n && !sdaOe)
        else $error("alert or sda active at reset release");
    chk_reset_ports: assert property ($rose(arst_n) |->
        portDrive.pullupEn == PE_PULL_RESET && portDrive.odioOe == 4'h0)
        else $error("ports not at reset state");
    chk_flags_clear: assert property (quietStart |-> changeAlert_n)
        else $error("false alert after reset");
    chk_pp_default: assert property (relDone |->
        portDrive.pp == {{2{addrSelectHigh}}, {2{addrSelectLow}}})
        else $error("pp not at straps");
    chk_pull_default: assert property (relDone |->
        portDrive.pullupEn == {{2{addrSelectHigh}}, {2{addrSelectLow}}})
        else $error("pullups not at straps");
    chk_pull_pairs: assert property (portDrive.pullupEn[0] == portDrive.pullupEn[1]
        && portDrive.pullupEn[2] == portDrive.pullupEn[3])
        else $error("pullups split inside a pair");
    chk_abort_alert: assert property (!busAbort_n && !changeAlert_n |=> !changeAlert_n)
        else $error("abort cleared the alert");
    chk_abort_idle: assert property (abortHeld |-> ##6 !sdaOe)
        else $error("sda driven during abort");
endmodule : pe_reset_addr_select_monitor
`default_nettype wire

/* File: dv/pe_i2c_master.sv */
// behavioural i2c bus master driving scl and pulling sda low
// assumes sdaLine is the resolved, pulled-up data wire
`timescale 1ns/100ps
`default_nettype none
module pe_i2c_master (
    // clock and bus
    input wire logic clock,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaLow
);
    // bus idle: both lines released high
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // half bit, well above the slave's sampling and answer latency
    task automatic phase;
        repeat (24) @(posedge clock);
    endtask : phase
    // sda moves only after scl has settled low, so no false start or stop
    task automatic xbit(input logic b, output logic r);
        sdaLow <= !b;
        phase();
        scl <= 1'b1;
        phase();
        r = sdaLine;
        scl <= 1'b0;
        repeat (6) @(posedge clock);
    endtask : xbit
    task automatic start;
        sdaLow <= 1'b1;
        phase();
        scl <= 1'b0;
        repeat (6) @(posedge clock);
    endtask : start
    task automatic stop;
        sdaLow <= 1'b1;
        phase();
        scl <= 1'b1;
        phase();
        sdaLow <= 1'b0;
        phase();
    endtask : stop
    task automatic wbyte(input logic [7:0] d, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, nack);
    endtask : wbyte
    // last high leaves sda released, a not-acknowledge
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
        xbit(last, r);
    endtask : rbyte
endmodule : pe_i2c_master
`default_nettype wire

/* File: dv/pe_reset_addr_select_tb.sv */
// bench: strap defaults per reset, writes, reads, alert, abort
// assumes pe_i2c_master as bus partner and the checker bound below
`timescale 1ns/100ps
`default_nettype none
module pe_reset_addr_select_tb;
    import pe_pkg::*;
    typedef struct packed {
        pe_sel_class_type hi;
        pe_sel_class_type lo;
        logic [3:0] exp;
    } pe_row_type;
    localparam pe_row_type ROWS [5] = '{'{PE_SEL_GND, PE_SEL_GND, 4'h0},
        '{PE_SEL_GND, PE_SEL_VDD, 4'h3}, '{PE_SEL_VDD, PE_SEL_GND, 4'hC},
        '{PE_SEL_VDD, PE_SEL_VDD, 4'hF}, '{PE_SEL_SCL, PE_SEL_SDA, 4'hF}};
    logic clock, linkClock, arst_n, busAbort_n, nack, scl, sdaLow, sdaOut, sdaOe;
    logic changeAlert_n, sdaLine, selLow, selHigh;
    logic [7:0] portPins, rd;
    pe_sel_class_type hiMode, loMode;
    pe_port_drive_type portDrive;
    int error_cnt = 0;
    int num_checks = 0;
    // wired-and data line with pull-up; straps follow a fixed level or a bus line
    assign sdaLine = !(sdaLow || sdaOe);
    assign selLow = loMode == PE_SEL_SCL ? scl : loMode == PE_SEL_SDA ? sdaLine : loMode[0];
    assign selHigh = hiMode == PE_SEL_SCL ? scl : hiMode == PE_SEL_SDA ? sdaLine : hiMode[0];
    pe_reset_addr_select dut (.clock(clock), .arst_n(arst_n), .linkClock(linkClock),
        .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelectLow(selLow),
        .addrSelectHigh(selHigh), .busAbort_n(busAbort_n), .portLevelIn(portPins),
        .portDrive(portDrive), .changeAlert_n(changeAlert_n));
    pe_i2c_master mst (.clock(clock), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // offset so link edges never meet main edges
    initial begin
        linkClock = 1'b0;
        #1.3;
        forever #6 linkClock = ~linkClock;
    end
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", name, exp, got);
        end
    endtask : check
    task automatic doReset;
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        repeat (20) @(posedge clock);
    endtask : doReset
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic expNack);
        mst.start();
        mst.wbyte({a, 1'b0}, nack);
        check("addr ack", 8'(expNack), 8'(nack));
        mst.wbyte(d, nack);
        mst.stop();
        repeat (12) @(posedge clock);
    endtask : wr
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (40000) @(posedge clock);
        error_cnt++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'b0;
        busAbort_n = 1'b1;
        portPins = 8'hC3;
        // one reset per strap row, bus idle
        foreach (ROWS[i]) begin
            hiMode <= ROWS[i].hi;
            loMode <= ROWS[i].lo;
            doReset();
            check("pp default", 8'(ROWS[i].exp), 8'(portDrive.pp));
            check("pullups", 8'(ROWS[i].exp), 8'(portDrive.pullupEn));
            check("alert idle", 8'h01, 8'(changeAlert_n));
        end
        // straps now scl/sda: learned on the first transmission
        wr(7'h00, 8'h00, 1'b1);
        wr(7'h63, 8'hA5, 1'b0);
        check("pp write", 8'h09, 8'(portDrive.pp));
        check("io drive", 8'h06, 8'(portDrive.odioOe));
        loMode <= PE_SEL_GND;
        wr(7'h63, 8'h00, 1'b1);
        wr(7'h60, 8'h5A, 1'b0);
        check("pullups", 8'h0C, 8'(portDrive.pullupEn));
        check("pp write", 8'h06, 8'(portDrive.pp));
        // io change raises alert; abort keeps it
        portPins <= 8'hC7;
        for (int k = 0; k < 200 && changeAlert_n !== 1'b0; k++) @(posedge clock);
        check("alert set", 8'h00, 8'(changeAlert_n));
        busAbort_n <= 1'b0;
        repeat (20) @(posedge clock);
        busAbort_n <= 1'b1;
        repeat (12) @(posedge clock);
        check("alert kept", 8'h00, 8'(changeAlert_n));
        mst.start();
        mst.wbyte({7'h60, 1'b1}, nack);
        mst.rbyte(1'b0, rd);
        check("port byte", 8'hC7, rd);
        mst.rbyte(1'b1, rd);
        check("flag byte", 8'h04, rd);
        mst.stop();
        repeat (12) @(posedge clock);
        check("alert clear", 8'h01, 8'(changeAlert_n));
        // abort while a read bit is driven, then a clean write
        portPins <= 8'h47;
        mst.start();
        mst.wbyte({7'h60, 1'b1}, nack);
        busAbort_n <= 1'b0;
        repeat (20) @(posedge clock);
        check("sda free", 8'h00, 8'(sdaOe));
        busAbort_n <= 1'b1;
        repeat (12) @(posedge clock);
        mst.stop();
        wr(7'h60, 8'hFF, 1'b0);
        check("pp after abort", 8'h0F, 8'(portDrive.pp));
        print_verdict();
    end
endmodule : pe_reset_addr_select_tb
bind pe_reset_addr_select pe_reset_addr_select_monitor mon (.clock(clock), .arst_n(arst_n),
    .sdaOe(sdaOe), .addrSelectLow(addrSelectLow), .addrSelectHigh(addrSelectHigh),
    .busAbort_n(busAbort_n), .portLevelIn(portLevelIn), .portDrive(portDrive),
    .changeAlert_n(changeAlert_n));
`default_nettype wire
